/* File: src/sdrc_defs.vh */
// constants for the reclocker control block
`ifndef SDRC_DEFS_VH
`define SDRC_DEFS_VH

`define SDRC_REG_CTRL        4'h0
`define SDRC_REG_STATUS      4'h1
`define SDRC_REG_RATE        4'h2

`define SDRC_RATE_AUTO       2'h0
`define SDRC_RATE_SD270      2'h1
`define SDRC_RATE_HD         2'h2
`define SDRC_RATE_TEST       2'h3

`define SDRC_DET_NONE        3'h0
`define SDRC_DET_143         3'h1
`define SDRC_DET_270         3'h2
`define SDRC_DET_1483        3'h3
`define SDRC_DET_1485        3'h4
`define SDRC_DET_177         3'h5
`define SDRC_DET_360         3'h6
`define SDRC_DET_540         3'h7

`define SDRC_CLK_HZ          125000000
`define SDRC_REF_HZ          27000000
`define SDRC_LOSS_US         1000
`define SDRC_ACQ_AUTO_US     16000
`define SDRC_ACQ_FIXED_US    6000

`define SDRC_CTRL_CLKOUT     0
`define SDRC_CTRL_MUTE_N     1
`define SDRC_CTRL_BYPASS     2
`define SDRC_CTRL_SEL_LO     3
`define SDRC_CTRL_RATE_LO    5
`define SDRC_CTRL_MSB        7
`define SDRC_CTRL_RESET      8'h02

`endif

/* File: src/sdrc_sync2.v */
// two-stage synchroniser for a bus of static control levels
`timescale 1ns/1ps
module sdrc_sync2 #(
    parameter             WIDTH = 1,
    parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
    input  wire             core_clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1  <= INIT;
            syncOut <= INIT;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

/* File: src/sdrc_reclocker_ctrl.v */
// control and indicator logic of the four-input sdi reclocker
// Notes on behaviour
// - retime only at 143, 270, 1483, 1485 Mbps; never lock on harmonics
// - 177, 360, 540 Mbps stay unlocked and pass through in bypass
// - clock-mode second output edge within ten percent of bit centre
// - clock enable low gives second data output, high gives rate clock
// - clock enable pin defaults low when undriven
// - clock-mode second output is muted while bypass is active
// - low mute input mutes both outputs, over any bypass
// - mute input defaults high, outputs enabled when unconnected
// - rate code 00 automatic, 01 fixed 270, 10 fixed high definition
// - 143 Mbps only reachable under automatic rate detection
// - both rate pins default low, so automatic detection by default
// - input select 00..11 routes exactly one of inputs 0..3
// - lock indicator high only with data present and loop locked
// - lock wired to mute input mutes outputs while unlocked
// - bypass input high forces unreclocked pass-through; pin defaults low
// - bypass low: auto bypass when unlocked or rate unsupported
// - rate indicator high for 270 or 143, low for 1483 or 1485
// - rate indicator registered and valid only while lock is high
// - rate indicator forced low while unlocked
// - lock drops within 1 ms after input select change
// - control timing counted in 125 MHz core clock cycles; only the rate indicator wait uses the 27 MHz reference period
// - lock within 16 ms automatic, 6 ms fixed, from first transition
// - muted output pairs held at opposite static levels
`timescale 1ns/1ps
`include "sdrc_defs.vh"
module sdrc_reclocker_ctrl #(
    parameter LOSS_CYC      = (`SDRC_CLK_HZ / 1000000) * `SDRC_LOSS_US,
    parameter ACQ_AUTO_CYC  = (`SDRC_CLK_HZ / 1000000) * `SDRC_ACQ_AUTO_US,
    parameter ACQ_FIXED_CYC = (`SDRC_CLK_HZ / 1000000) * `SDRC_ACQ_FIXED_US,
    parameter REF_CYC       = (`SDRC_CLK_HZ + `SDRC_REF_HZ - 1) / `SDRC_REF_HZ
) (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [3:0]  avs_address,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire [3:0]  serialInputPresent,
    input  wire [11:0] serialInputRate,
    input  wire        loopLocked,
    output reg         lockIndicator,
    output reg         rateIndicator,
    output reg  [1:0]  inputSelect,
    output reg  [1:0]  loopRateMode,
    output reg         reclockBypass,
    output reg         retimedDataMute,
    output reg         secondOutputMute,
    output reg         secondOutputClock,
    output reg         mutedTrueLevel,
    output reg         testMode
);
    ////////////////////////////////////////////////////////////////////////
    // control register, reset values match the pin pull defaults
    reg  [7:0] ctrlReg;
    wire [7:0] ctrlSync;
    wire [2:0] rateSync;
    wire [3:0] presSync;
    wire       lockSync;

    function [2:0] rateOf;
        input [11:0] rates;
        input [1:0]  idx;
        begin
            case (idx)
                2'h0:    rateOf = rates[2:0];
                2'h1:    rateOf = rates[5:3];
                2'h2:    rateOf = rates[8:6];
                default: rateOf = rates[11:9];
            endcase
        end
    endfunction

    function supported;
        input [2:0] r;
        input [1:0] mode;
        begin
            case (mode)
                `SDRC_RATE_AUTO:  supported = (r == `SDRC_DET_143) || (r == `SDRC_DET_270) ||
                                              (r == `SDRC_DET_1483) || (r == `SDRC_DET_1485);
                `SDRC_RATE_SD270: supported = (r == `SDRC_DET_270);
                `SDRC_RATE_HD:    supported = (r == `SDRC_DET_1483) || (r == `SDRC_DET_1485);
                default:          supported = 1'b0;
            endcase
        end
    endfunction

    sdrc_sync2 #(.WIDTH(8), .INIT(`SDRC_CTRL_RESET)) uCtrlSync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .asyncIn  (ctrlReg),
        .syncOut  (ctrlSync)
    );

    // analogue-side status comes from another domain
    sdrc_sync2 #(.WIDTH(8)) uStatSync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .asyncIn  ({serialInputPresent, rateOf(serialInputRate, ctrlSync[`SDRC_CTRL_SEL_LO +: 2]), loopLocked}),
        .syncOut  ({presSync, rateSync, lockSync})
    );

    wire       clkOutEn = ctrlSync[`SDRC_CTRL_CLKOUT];
    wire       muteN    = ctrlSync[`SDRC_CTRL_MUTE_N];
    wire       bypassIn = ctrlSync[`SDRC_CTRL_BYPASS];
    wire [1:0] selCode  = ctrlSync[`SDRC_CTRL_SEL_LO +: 2];
    wire [1:0] rateCode = ctrlSync[`SDRC_CTRL_RATE_LO +: 2];

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then answer
    // a request still held in the answer cycle is not taken a second time
    reg        accept;
    reg [31:0] next_readdata;

    always @* begin
        accept        = (avs_read || avs_write) && avs_waitrequest;
        next_readdata = avs_readdata;
        if (accept) begin
            case (avs_address)
                `SDRC_REG_CTRL: begin
                    next_readdata = {24'h000000, ctrlReg};
                end
                `SDRC_REG_STATUS: begin
                    next_readdata = {26'h0000000, testMode, reclockBypass, secondOutputMute,
                                     retimedDataMute, rateIndicator, lockIndicator};
                end
                `SDRC_REG_RATE: begin
                    next_readdata = {25'h0000000, presSync, rateSync};
                end
                default: begin
                    next_readdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlReg         <= `SDRC_CTRL_RESET;
            avs_readdata    <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !accept;
            avs_readdata    <= next_readdata;
            if (accept && avs_write && (avs_address == `SDRC_REG_CTRL)) begin
                ctrlReg <= avs_writedata[`SDRC_CTRL_MSB:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock tracking
    reg  [1:0]  selPrev;
    reg  [1:0]  ratePrev;
    reg  [31:0] acqCnt;
    reg  [31:0] refCnt;
    reg  [31:0] lossCnt;
    reg         lossPending;
    reg         lockPrev;
    reg         rateValid;
    reg  [31:0] next_acqCnt;
    reg  [31:0] next_refCnt;
    reg  [31:0] next_lossCnt;
    reg         next_lossPending;
    reg         next_rateValid;
    reg         next_lock;
    reg         next_rate;
    wire        present  = presSync[selCode];
    wire        goodRate = supported(rateSync, rateCode);
    wire        changed  = (selPrev != selCode) || (ratePrev != rateCode);
    wire        lockEdge = (lockIndicator != lockPrev);
    wire        lossDue  = lossPending && (lossCnt >= LOSS_CYC - 1);
    wire [31:0] acqLimit = (rateCode == `SDRC_RATE_AUTO) ? ACQ_AUTO_CYC : ACQ_FIXED_CYC;

    // acquisition counts from first transition and restarts on any change
    always @* begin
        next_acqCnt = acqCnt;
        if (!present || changed) begin
            next_acqCnt = 32'h0000_0000;
        end else if (acqCnt < acqLimit) begin
            next_acqCnt = acqCnt + 32'h0000_0001;
        end
    end

    // watchdog: a lock that outlives a channel change is cut after the loss time
    always @* begin
        next_lossPending = lossPending;
        next_lossCnt     = lossCnt;
        if (!lockIndicator) begin
            next_lossPending = 1'b0;
            next_lossCnt     = 32'h0000_0000;
        end else if (changed) begin
            next_lossPending = 1'b1;
            next_lossCnt     = 32'h0000_0000;
        end else if (lossPending && !lossDue) begin
            next_lossCnt = lossCnt + 32'h0000_0001;
        end
    end

    always @* begin
        next_lock = 1'b0;
        if (present && lockSync && goodRate && !changed && !lossDue) begin
            if (lockIndicator || (acqCnt >= acqLimit)) begin
                next_lock = 1'b1;
            end
        end
    end

    // rate indicator waits one reference period after every lock edge
    always @* begin
        next_refCnt    = refCnt;
        next_rateValid = rateValid;
        if (lockEdge) begin
            next_refCnt    = 32'h0000_0000;
            next_rateValid = 1'b0;
        end else if (refCnt < REF_CYC - 1) begin
            next_refCnt = refCnt + 32'h0000_0001;
        end else begin
            next_rateValid = 1'b1;
        end
    end

    // the stale valid flag must not let the edge cycle itself update the indicator
    always @* begin
        next_rate = rateIndicator;
        if (!lockIndicator) begin
            next_rate = 1'b0;
        end else if (rateValid && !lockEdge) begin
            next_rate = (rateSync == `SDRC_DET_143) || (rateSync == `SDRC_DET_270);
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            selPrev       <= 2'h0;
            ratePrev      <= 2'h0;
            acqCnt        <= 32'h0000_0000;
            refCnt        <= 32'h0000_0000;
            lossCnt       <= 32'h0000_0000;
            lossPending   <= 1'b0;
            lockPrev      <= 1'b0;
            rateValid     <= 1'b0;
            lockIndicator <= 1'b0;
            rateIndicator <= 1'b0;
        end else begin
            selPrev       <= selCode;
            ratePrev      <= rateCode;
            acqCnt        <= next_acqCnt;
            refCnt        <= next_refCnt;
            lossCnt       <= next_lossCnt;
            lossPending   <= next_lossPending;
            lockPrev      <= lockIndicator;
            rateValid     <= next_rateValid;
            lockIndicator <= next_lock;
            rateIndicator <= next_rate;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output steering
    reg next_bypass;
    reg next_muteData;
    reg next_muteSecond;
    reg next_clockOut;
    reg next_testMode;

    always @* begin
        next_testMode   = (rateCode == `SDRC_RATE_TEST);
        next_clockOut   = clkOutEn;
        next_bypass     = bypassIn || !lockIndicator;
        // mute is decided apart from bypass, so it always wins
        next_muteData   = !muteN;
        next_muteSecond = !muteN;
        if (clkOutEn && next_bypass) begin
            next_muteSecond = 1'b1;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            inputSelect       <= 2'h0;
            loopRateMode      <= `SDRC_RATE_AUTO;
            reclockBypass     <= 1'b1;
            retimedDataMute   <= 1'b0;
            secondOutputMute  <= 1'b0;
            secondOutputClock <= 1'b0;
            mutedTrueLevel    <= 1'b0;
            testMode          <= 1'b0;
        end else begin
            inputSelect       <= selCode;
            loopRateMode      <= rateCode;
            testMode          <= next_testMode;
            reclockBypass     <= next_bypass;
            secondOutputClock <= next_clockOut;
            retimedDataMute   <= next_muteData;
            secondOutputMute  <= next_muteSecond;
            // true leg low, complement high: opposite static levels while muted
            mutedTrueLevel    <= 1'b0;
        end
    end
endmodule

/* File: verif/sdrc_ctrl_props.sv */
// port assertions for the reclocker control block
`timescale 1ns/1ps
module sdrc_ctrl_props (
    input logic       core_clk,
    input logic       sys_rst,
    input logic       avs_read,
    input logic       avs_write,
    input logic       avs_waitrequest,
    input logic       loopLocked,
    input logic       lockIndicator,
    input logic       rateIndicator,
    input logic [1:0] inputSelect,
    input logic       reclockBypass,
    input logic       retimedDataMute,
    input logic       secondOutputMute,
    input logic       secondOutputClock,
    input logic       mutedTrueLevel,
    input logic       testMode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
    a_bus_answer: assert property (s_req |=> s_ans) else $error("bus answer late or long");
    a_lock_loop: assert property (!loopLocked[*5] |-> !lockIndicator) else $error("lock without loop");
    a_rate_unlock: assert property (!lockIndicator[*7] |-> !rateIndicator) else $error("rate high unlocked");
    a_auto_bypass: assert property (!lockIndicator[*3] |-> reclockBypass) else $error("no bypass unlocked");
    a_sel_unlock: assert property ($changed(inputSelect) |-> ##[0:8] !lockIndicator) else $error("lock kept");
    a_clock_bypass: assert property ((secondOutputClock && reclockBypass)[*2] |-> secondOutputMute)
        else $error("clock output not muted in bypass");
    a_mute_both: assert property (retimedDataMute |-> secondOutputMute) else $error("second not muted");
    a_test_nolock: assert property (testMode[*8] |-> !lockIndicator) else $error("lock in test mode");
    a_mute_level: assert property (retimedDataMute |-> !mutedTrueLevel) else $error("muted level wrong");
endmodule
bind sdrc_reclocker_ctrl sdrc_ctrl_props i_props (.core_clk, .sys_rst, .avs_read, .avs_write,
    .avs_waitrequest, .loopLocked, .lockIndicator, .rateIndicator, .inputSelect, .reclockBypass,
    .retimedDataMute, .secondOutputMute, .secondOutputClock, .mutedTrueLevel, .testMode);

/* File: verif/sdrc_far_model.sv */
// equalizer and analog loop model in front of the control block
`timescale 1ns/1ps
module sdrc_far_model (
    input  wire logic        core_clk,
    input  wire logic [3:0]  present,
    input  wire logic [1:0]  inputSelect,
    input  wire logic [1:0]  loopRateMode,
    output logic      [3:0]  serialInputPresent,
    output logic      [11:0] serialInputRate,
    output logic             loopLocked
);
    logic [2:0] r;
    logic       ok;
    logic [2:0] cnt = 3'h0;
    logic [1:0] lastSel = 2'h0;
    assign serialInputPresent = present;
    // inputs 3..0 carry 143, 177, 1485, 270
    assign serialInputRate = {3'h1, 3'h5, 3'h4, 3'h2};
    assign r = serialInputRate[inputSelect*3 +: 3];
    always_comb begin
        case (loopRateMode)
            2'h0: ok = (r >= 3'h1) && (r <= 3'h4);
            2'h1: ok = (r == 3'h2);
            2'h2: ok = (r == 3'h3) || (r == 3'h4);
            default: ok = 1'b0;
        endcase
    end
    // the loop re-acquires after every channel change, never keeps an old lock
    always @(posedge core_clk) begin
        lastSel <= inputSelect;
        if (!(ok && present[inputSelect]) || inputSelect != lastSel) cnt <= 3'h0;
        else if (cnt != 3'h4) cnt <= cnt + 3'h1;
    end
    assign loopLocked = (cnt == 3'h4);
endmodule

/* File: verif/tb_sdrc_reclocker_ctrl.sv */
// self-checking bench for the reclocker control block
`timescale 1ns/1ps
module tb_sdrc_reclocker_ctrl;
    logic        core_clk, sys_rst, avs_read, avs_write, avs_waitrequest, loopLocked, lockIndicator;
    logic        rateIndicator, reclockBypass, retimedDataMute, secondOutputMute, secondOutputClock;
    logic        mutedTrueLevel, testMode;
    logic [3:0]  avs_address, serialInputPresent, present;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [11:0] serialInputRate;
    logic [1:0]  inputSelect, loopRateMode;
    int          mismatches = 0, totalChecks = 0;
    sdrc_reclocker_ctrl #(.LOSS_CYC(20), .ACQ_AUTO_CYC(200), .ACQ_FIXED_CYC(100)) i_dut (.core_clk, .sys_rst,
        .avs_read, .avs_write, .avs_address, .avs_writedata, .avs_readdata, .avs_waitrequest, .serialInputPresent,
        .serialInputRate, .loopLocked, .lockIndicator, .rateIndicator, .inputSelect, .loopRateMode, .reclockBypass,
        .retimedDataMute, .secondOutputMute, .secondOutputClock, .mutedTrueLevel, .testMode);
    sdrc_far_model i_far (.core_clk, .present, .inputSelect, .loopRateMode, .serialInputPresent,
        .serialInputRate, .loopLocked);
    ////////////////////////////////////////////////////////////////
    task summarize;
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        avs_address <= a; avs_writedata <= d; avs_write <= wr; avs_read <= !wr;
        n = 0;
        do begin @(posedge core_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0; avs_read <= 1'b0;
        if (n == 50) begin mismatches++; summarize(); end
        @(posedge core_clk);
    endtask
    task waitLock(input logic e, input int lim);
        int n;
        n = 0;
        while (lockIndicator !== e && n < lim) begin @(posedge core_clk); n++; end
        chk("lock", {31'h0, e}, {31'h0, lockIndicator});
        if (n == lim) summarize();
    endtask
    task ctl(input logic c, input logic m, input logic b, input logic [1:0] s, input logic [1:0] r);
        xfer(1'b1, 4'h0, {25'h0, r, s, b, m, c});
        repeat (4) @(posedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        sys_rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0; avs_writedata = 32'h0; present = 4'h0;
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0; present <= 4'hF;
        xfer(1'b0, 4'h0, 32'h0); chk("ctrl", 32'h02, q);
        xfer(1'b0, 4'h1, 32'h0); chk("status", 32'h10, q);
        xfer(1'b1, 4'hF, 32'hFF); xfer(1'b0, 4'hF, 32'h0); chk("unmapped", 32'h0, q);
        $display("test defaults done");
        waitLock(1'b1, 1000);
        repeat (7) @(posedge core_clk); chk("rate", 32'h1, rateIndicator);
        chk("bypass", 32'h0, reclockBypass);
        ctl(0, 1, 0, 2'h1, 2'h0); waitLock(1'b0, 20);
        waitLock(1'b1, 1000); repeat (7) @(posedge core_clk); chk("rate", 32'h0, rateIndicator);
        $display("test auto rate done");
        ctl(0, 1, 0, 2'h3, 2'h1); repeat (300) @(posedge core_clk); chk("lock", 32'h0, lockIndicator);
        chk("bypass", 32'h1, reclockBypass); chk("mode", 32'h1, loopRateMode);
        ctl(0, 1, 0, 2'h0, 2'h1); waitLock(1'b1, 1000);
        ctl(0, 1, 0, 2'h1, 2'h2); waitLock(1'b1, 1000); chk("mode", 32'h2, loopRateMode);
        ctl(0, 1, 0, 2'h2, 2'h0); repeat (300) @(posedge core_clk); chk("lock", 32'h0, lockIndicator);
        chk("bypass", 32'h1, reclockBypass);
        ctl(0, lockIndicator, 0, 2'h2, 2'h0); chk("mute", 32'h1, retimedDataMute);
        chk("level", 32'h0, mutedTrueLevel);
        $display("test fixed rates done");
        ctl(1, 1, 1, 2'h0, 2'h0); waitLock(1'b1, 1000); chk("bypass", 32'h1, reclockBypass);
        chk("clk", 32'h1, secondOutputClock); chk("mute2", 32'h1, secondOutputMute);
        ctl(1, 0, 0, 2'h0, 2'h0); chk("mute", 32'h1, retimedDataMute); chk("mute2", 32'h1, secondOutputMute);
        ctl(0, 1, 0, 2'h0, 2'h0); chk("clk", 32'h0, secondOutputClock); chk("mute", 32'h0, retimedDataMute);
        for (int i = 0; i < 4; i++) begin
            ctl(0, 1, 0, i[1:0], 2'h3); chk("sel", {30'h0, i[1:0]}, inputSelect); chk("test", 32'h1, testMode);
        end
        $display("test outputs done");
        summarize();
    end
endmodule
